//--- cid_pkg.sv
// Shared constants and types for the instruction timing and decode block
package cid_pkg;

  // ------------------------------------------------------------------
  // Special-function space map
  // ------------------------------------------------------------------
  localparam logic [7:0] SFR_DP_LOW = 8'h82;
  localparam logic [7:0] SFR_DP_HIGH = 8'h83;
  localparam logic [7:0] DP_RESET = 8'h00;
  localparam logic [7:0] SFR_UNMAPPED = 8'h00;
  localparam int DIRECT_SPACE_BIT = 7;

  // ------------------------------------------------------------------
  // Opcodes the block singles out
  // ------------------------------------------------------------------
  localparam logic [7:0] OP_UNUSED = 8'ha5;
  localparam logic [7:0] OP_NOP = 8'h00;
  localparam logic [7:0] OP_LOAD_DP = 8'h90;

  // ------------------------------------------------------------------
  // Widths and field positions
  // ------------------------------------------------------------------
  localparam int PC_W = 16;
  localparam int PAGE_LSB = 11;
  localparam int CYC_W = 3;
  localparam int PAGE_OP_MSB = 7;
  localparam int PAGE_OP_LSB = 5;
  localparam logic [CYC_W-1:0] CYC_ONE = 3'h1;

  // Branch class of an instruction
  typedef enum logic [2:0] {
    BR_NONE = 3'b000,
    BR_COND = 3'b001,
    BR_REL = 3'b010,
    BR_PAGE = 3'b011,
    BR_FULL = 3'b100,
    BR_IND = 3'b101,
    BR_RET = 3'b110
  } cid_branch_t;

  // Condition tested by a conditional branch
  typedef enum logic [3:0] {
    C_NONE = 4'b0000,
    C_CARRY = 4'b0001,
    C_NCARRY = 4'b0010,
    C_ZERO = 4'b0011,
    C_NZERO = 4'b0100,
    C_BIT = 4'b0101,
    C_NBIT = 4'b0110,
    C_BITCLR = 4'b0111,
    C_UNEQ = 4'b1000,
    C_DECNZ = 4'b1001
  } cid_cond_t;

  // Sequencer states
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_RUN = 1'b1
  } cid_state_t;

  // One fetched instruction with the address of its first byte
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] op1;
    logic [7:0] op2;
    logic [PC_W-1:0] pc;
  } cid_instr_t;

  // Datapath conditions valid in the issue cycle
  typedef struct packed {
    logic carry;
    logic acc_zero;
    logic bit_set;
    logic unequal;
    logic dec_nonzero;
    logic [7:0] acc;
  } cid_flags_t;

  // Decoded properties of one opcode
  typedef struct packed {
    logic known;
    logic [1:0] len;
    logic [CYC_W-1:0] cycles;
    cid_branch_t branch;
    cid_cond_t cond;
    logic rel_in_op2;
    logic call;
    logic has_direct;
  } cid_decode_t;

endpackage

//--- cid_decoder.sv
// Opcode table: byte length, base cycle cost and branch class
module cid_decoder
  import cid_pkg::*;
(
  // Opcode in
  input wire logic [7:0] opcode,
  // Decoded properties out
  output cid_decode_t dec
);

  // Packs one table row; known is always set here
  function automatic cid_decode_t row(input logic [1:0] len,
                                      input logic [CYC_W-1:0] cyc,
                                      input cid_branch_t br,
                                      input cid_cond_t cnd,
                                      input logic rel2,
                                      input logic call,
                                      input logic dir);
    row = '{known: 1'b1, len: len, cycles: cyc, branch: br, cond: cnd,
            rel_in_op2: rel2, call: call, has_direct: dir};
  endfunction

  // ------------------------------------------------------------------
  // Table lookup, wildcard rows cover register and pointer groups
  // ------------------------------------------------------------------
  always_comb begin
    dec = '{known: 1'b0, len: 2'd1, cycles: 3'd1, branch: BR_NONE,
            cond: C_NONE, rel_in_op2: 1'b0, call: 1'b0, has_direct: 1'b0};
    casez (opcode)
      // Logical with immediate into direct byte
      8'h53, 8'h43, 8'h63: dec = row(2'd3, 3'd3, BR_NONE, C_NONE,
                                     1'b0, 1'b0, 1'b1);
      8'h52, 8'h42, 8'h62, 8'h55, 8'h45, 8'h65:
        dec = row(2'd2, 3'd2, BR_NONE, C_NONE, 1'b0, 1'b0, 1'b1);
      8'h54, 8'h44, 8'h64:
        dec = row(2'd2, 3'd2, BR_NONE, C_NONE, 1'b0, 1'b0, 1'b0);
      8'b0101_011?, 8'b0100_011?, 8'b0110_011?:
        dec = row(2'd1, 3'd2, BR_NONE, C_NONE, 1'b0, 1'b0, 1'b0);
      8'b0101_1???, 8'b0100_1???, 8'b0110_1???:
        dec = row(2'd1, 3'd1, BR_NONE, C_NONE, 1'b0, 1'b0, 1'b0);
      // Accumulator only
      8'he4, 8'hf4, 8'h23, 8'h33, 8'h03, 8'h13, 8'hc4:
        dec = row(2'd1, 3'd1, BR_NONE, C_NONE, 1'b0, 1'b0, 1'b0);
      // Bank register moves and exchange
      8'b1110_1???, 8'b1111_1???, 8'b1100_1???:
        dec = row(2'd1, 3'd1, BR_NONE, C_NONE, 1'b0, 1'b0, 1'b0);
      // Indirect pointer moves and exchange
      8'b1110_011?, 8'b1111_011?, 8'b1100_011?:
        dec = row(2'd1, 3'd2, BR_NONE, C_NONE, 1'b0, 1'b0, 1'b0);
      8'h85, 8'h75: dec = row(2'd3, 3'd3, BR_NONE, C_NONE,
                              1'b0, 1'b0, 1'b1);
      8'he5, 8'hf5, 8'hc5, 8'b1000_1???, 8'b1010_1???, 8'b1000_011?,
      8'b1010_011?:
        dec = row(2'd2, 3'd2, BR_NONE, C_NONE, 1'b0, 1'b0, 1'b1);
      8'h74, 8'b0111_1???, 8'b0111_011?:
        dec = row(2'd2, 3'd2, BR_NONE, C_NONE, 1'b0, 1'b0, 1'b0);
      OP_LOAD_DP: dec = row(2'd3, 3'd3, BR_NONE, C_NONE,
                            1'b0, 1'b0, 1'b0);
      8'h93, 8'h83: dec = row(2'd1, 3'd3, BR_NONE, C_NONE,
                              1'b0, 1'b0, 1'b0);
      8'b1110_001?, 8'b1111_001?, 8'he0, 8'hf0:
        dec = row(2'd1, 3'd3, BR_NONE, C_NONE, 1'b0, 1'b0, 1'b0);
      8'hc0, 8'hd0: dec = row(2'd2, 3'd2, BR_NONE, C_NONE,
                              1'b0, 1'b0, 1'b1);
      8'b1101_011?: dec = row(2'd1, 3'd2, BR_NONE, C_NONE,
                              1'b0, 1'b0, 1'b0);
      // Boolean on carry, then on a direct bit
      8'hc3, 8'hd3, 8'hb3: dec = row(2'd1, 3'd1, BR_NONE, C_NONE,
                                     1'b0, 1'b0, 1'b0);
      8'hc2, 8'hd2, 8'hb2, 8'h82, 8'hb0, 8'h72, 8'ha0, 8'ha2, 8'h92:
        dec = row(2'd2, 3'd2, BR_NONE, C_NONE, 1'b0, 1'b0, 1'b1);
      // Conditional jumps on carry or zero accumulator
      8'h40: dec = row(2'd2, 3'd2, BR_COND, C_CARRY, 1'b0, 1'b0, 1'b0);
      8'h50: dec = row(2'd2, 3'd2, BR_COND, C_NCARRY, 1'b0, 1'b0, 1'b0);
      8'h60: dec = row(2'd2, 3'd2, BR_COND, C_ZERO, 1'b0, 1'b0, 1'b0);
      8'h70: dec = row(2'd2, 3'd2, BR_COND, C_NZERO,
                       1'b0, 1'b0, 1'b0);
      // Bit tests
      8'h20: dec = row(2'd3, 3'd3, BR_COND, C_BIT, 1'b1, 1'b0, 1'b1);
      8'h30: dec = row(2'd3, 3'd3, BR_COND, C_NBIT, 1'b1, 1'b0, 1'b1);
      8'h10: dec = row(2'd3, 3'd3, BR_COND, C_BITCLR,
                       1'b1, 1'b0, 1'b1);
      // Compare and branch
      8'hb5: dec = row(2'd3, 3'd4, BR_COND, C_UNEQ, 1'b1, 1'b0, 1'b1);
      8'b1011_011?: dec = row(2'd3, 3'd4, BR_COND, C_UNEQ,
                              1'b1, 1'b0, 1'b0);
      8'hb4, 8'b1011_1???: dec = row(2'd3, 3'd3, BR_COND, C_UNEQ,
                                     1'b1, 1'b0, 1'b0);
      // Decrement and branch
      8'b1101_1???: dec = row(2'd2, 3'd2, BR_COND, C_DECNZ,
                              1'b0, 1'b0, 1'b0);
      8'hd5: dec = row(2'd3, 3'd3, BR_COND, C_DECNZ, 1'b1, 1'b0, 1'b1);
      // Calls and jumps
      8'b???1_0001: dec = row(2'd2, 3'd3, BR_PAGE, C_NONE,
                              1'b0, 1'b1, 1'b0);
      8'h12: dec = row(2'd3, 3'd4, BR_FULL, C_NONE, 1'b0, 1'b1, 1'b0);
      8'h22, 8'h32: dec = row(2'd1, 3'd5, BR_RET, C_NONE,
                              1'b0, 1'b0, 1'b0);
      8'b???0_0001: dec = row(2'd2, 3'd3, BR_PAGE, C_NONE,
                              1'b0, 1'b0, 1'b0);
      8'h02: dec = row(2'd3, 3'd4, BR_FULL, C_NONE, 1'b0, 1'b0, 1'b0);
      8'h80: dec = row(2'd2, 3'd3, BR_REL, C_NONE, 1'b0, 1'b0, 1'b0);
      8'h73: dec = row(2'd1, 3'd3, BR_IND, C_NONE,
                       1'b0, 1'b0, 1'b0);
      // Spare opcode behaves as the idle instruction
      OP_NOP, OP_UNUSED: dec = row(2'd1, 3'd1, BR_NONE, C_NONE,
                                   1'b0, 1'b0, 1'b0);
      default: dec = dec;
    endcase
  end

endmodule // cid_decoder

//--- cid_timing.sv
// Instruction timing sequencer with data pointer pair registers
// ------------------------------------------------------------------
// Top level
// ------------------------------------------------------------------
// Overview of operation
// - Logical immediate into direct: three bytes, cycles
// - Accumulator-only operations: one byte, one cycle
// - Bank register move one cycle, indirect two
// - Direct-to-direct and immediate-to-direct: three, three
// - Pointer pair immediate load: three bytes, cycles
// - Code byte read: one byte, three cycles
// - External data moves: one byte, three cycles
// - Push and pop direct: two bytes, cycles
// - Low nibble exchange: one byte, two cycles
// - Carry ops one cycle, direct bit two
// - Carry or zero jumps: two or three
// - Bit jumps three or four; only the clearing form clears on taken
// - Compare branch: four/five or three/four cycles
// - Decrement branch: register 2/3, direct 3/4
// - Short call three cycles, long call four
// - Both returns: one byte, five cycles
// - Jumps three cycles; full-range jump four
// - Relative target: next instruction plus signed offset
// - Direct address upper half selects function space
// - Page-local target kept in following page
// - Full-range target anywhere in program space
// - Spare opcode acts as no operation
// - Untaken branch one cycle shorter than taken
module cid_timing
  import cid_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Instruction issue
  input wire logic issue_valid,
  input cid_instr_t issue_instr,
  input cid_flags_t issue_flags,
  output logic issue_ready,
  // Completion and branch result
  output logic done,
  output logic taken,
  output logic [PC_W-1:0] next_pc,
  output logic call_push,
  output logic return_pop,
  output logic known,
  output logic [1:0] instr_len,
  output logic [CYC_W-1:0] cycles_used,
  output logic bit_clear,
  // Direct operand address
  output logic dir_valid,
  output logic [7:0] dir_addr,
  output logic dir_is_sfr,
  // Special-function register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // Data pointer pair
  output logic [7:0] data_pointer_low,
  output logic [7:0] data_pointer_high
);

  // ------------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------------
  cid_decode_t dec;

  cid_decoder u_decoder (
    .opcode (issue_instr.opcode),
    .dec    (dec)
  );

  // ------------------------------------------------------------------
  // Branch evaluation and target formation
  // ------------------------------------------------------------------
  logic accept;
  logic cond_true;
  logic br_taken;
  logic [7:0] rel_byte;
  logic [PC_W-1:0] fall_pc;
  logic [PC_W-1:0] rel_pc;
  logic [PC_W-1:0] page_pc;
  logic [PC_W-1:0] full_pc;
  logic [PC_W-1:0] ind_pc;
  logic [PC_W-1:0] target_pc;
  logic [CYC_W-1:0] total_cyc;

  assign accept = issue_valid & issue_ready;

  // Condition chosen by the decoder, sampled in the issue cycle
  always_comb begin
    case (dec.cond)
      C_CARRY: cond_true = issue_flags.carry;
      C_NCARRY: cond_true = ~issue_flags.carry;
      C_ZERO: cond_true = issue_flags.acc_zero;
      C_NZERO: cond_true = ~issue_flags.acc_zero;
      C_BIT: cond_true = issue_flags.bit_set;
      C_NBIT: cond_true = ~issue_flags.bit_set;
      C_BITCLR: cond_true = issue_flags.bit_set;
      C_UNEQ: cond_true = issue_flags.unequal;
      C_DECNZ: cond_true = issue_flags.dec_nonzero;
      default: cond_true = 1'b0;
    endcase
  end

  // Targets are all formed in parallel; the class picks one
  always_comb begin
    rel_byte = dec.rel_in_op2 ? issue_instr.op2 : issue_instr.op1;
    fall_pc = issue_instr.pc + {{(PC_W-2){1'b0}}, dec.len};
    // Offset counts from the first byte of the next instruction
    rel_pc = fall_pc + {{(PC_W-8){rel_byte[7]}}, rel_byte};
    // Upper page bits come from the following instruction's address
    page_pc = {fall_pc[PC_W-1:PAGE_LSB],
               issue_instr.opcode[PAGE_OP_MSB:PAGE_OP_LSB],
               issue_instr.op1};
    full_pc = {issue_instr.op1, issue_instr.op2};
    ind_pc = {data_pointer_high, data_pointer_low} +
             {{(PC_W-8){1'b0}}, issue_flags.acc};
    case (dec.branch)
      BR_COND: br_taken = cond_true;
      BR_REL, BR_PAGE, BR_FULL, BR_IND, BR_RET: br_taken = 1'b1;
      default: br_taken = 1'b0;
    endcase
    case (dec.branch)
      BR_COND, BR_REL: target_pc = br_taken ? rel_pc : fall_pc;
      BR_PAGE: target_pc = page_pc;
      BR_FULL: target_pc = full_pc;
      BR_IND: target_pc = ind_pc;
      default: target_pc = fall_pc;
    endcase
    // A taken conditional costs one cycle more than its table base
    total_cyc = dec.cycles +
      {{(CYC_W-1){1'b0}}, (dec.branch == BR_COND) & br_taken};
  end

  // ------------------------------------------------------------------
  // Cycle sequencer
  // ------------------------------------------------------------------
  cid_state_t state;
  cid_state_t next_state;
  logic [CYC_W-1:0] cnt;
  logic [CYC_W-1:0] next_cnt;
  logic next_issue_ready;
  logic next_done;
  logic pend_clear;
  logic next_pend_clear;
  logic next_bit_clear;

  // The issue cycle itself counts as the first cycle of execution
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_issue_ready = issue_ready;
    next_done = 1'b0;
    next_pend_clear = pend_clear;
    next_bit_clear = 1'b0;
    case (state)
      ST_IDLE: begin
        if (accept) begin
          // Clear only when the tested bit was set and the jump taken
          next_pend_clear = (dec.cond == C_BITCLR) & br_taken;
          if (total_cyc == CYC_ONE) begin
            next_done = 1'b1;
            next_bit_clear = next_pend_clear;
          end else begin
            next_state = ST_RUN;
            next_cnt = total_cyc - CYC_ONE;
            next_issue_ready = 1'b0;
          end
        end
      end
      ST_RUN: begin
        if (cnt == CYC_ONE) begin
          next_state = ST_IDLE;
          next_done = 1'b1;
          next_issue_ready = 1'b1;
          next_bit_clear = pend_clear;
        end
        next_cnt = cnt - CYC_ONE;
      end
      default: begin
        next_state = ST_IDLE;
        next_issue_ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= ST_IDLE;
      cnt <= '0;
      issue_ready <= 1'b1;
      done <= 1'b0;
      pend_clear <= 1'b0;
      bit_clear <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      issue_ready <= next_issue_ready;
      done <= next_done;
      pend_clear <= next_pend_clear;
      bit_clear <= next_bit_clear;
    end
  end

  // ------------------------------------------------------------------
  // Result registers, held from acceptance to the next acceptance
  // ------------------------------------------------------------------
  logic next_taken;
  logic [PC_W-1:0] next_next_pc;
  logic next_call_push;
  logic next_return_pop;
  logic next_known;
  logic [1:0] next_instr_len;
  logic [CYC_W-1:0] next_cycles_used;
  logic next_dir_valid;
  logic [7:0] next_dir_addr;
  logic next_dir_is_sfr;

  always_comb begin
    next_taken = taken;
    next_next_pc = next_pc;
    next_call_push = call_push;
    next_return_pop = return_pop;
    next_known = known;
    next_instr_len = instr_len;
    next_cycles_used = cycles_used;
    next_dir_valid = dir_valid;
    next_dir_addr = dir_addr;
    next_dir_is_sfr = dir_is_sfr;
    if (accept) begin
      next_taken = br_taken;
      next_next_pc = target_pc;
      next_call_push = dec.call;
      next_return_pop = dec.branch == BR_RET;
      next_known = dec.known;
      next_instr_len = dec.len;
      next_cycles_used = total_cyc;
      next_dir_valid = dec.has_direct;
      next_dir_addr = issue_instr.op1;
      // Lower half is data RAM, upper half the function space
      next_dir_is_sfr = issue_instr.op1[DIRECT_SPACE_BIT];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      taken <= 1'b0;
      next_pc <= '0;
      call_push <= 1'b0;
      return_pop <= 1'b0;
      known <= 1'b0;
      instr_len <= '0;
      cycles_used <= '0;
      dir_valid <= 1'b0;
      dir_addr <= '0;
      dir_is_sfr <= 1'b0;
    end else begin
      taken <= next_taken;
      next_pc <= next_next_pc;
      call_push <= next_call_push;
      return_pop <= next_return_pop;
      known <= next_known;
      instr_len <= next_instr_len;
      cycles_used <= next_cycles_used;
      dir_valid <= next_dir_valid;
      dir_addr <= next_dir_addr;
      dir_is_sfr <= next_dir_is_sfr;
    end
  end

  // ------------------------------------------------------------------
  // Data pointer pair and function-space port
  // ------------------------------------------------------------------
  logic [7:0] next_dp_low;
  logic [7:0] next_dp_high;
  logic [7:0] next_sfr_rdata;
  logic load_dp;

  // Instruction load wins over a port write in the same cycle
  always_comb begin
    load_dp = accept & (issue_instr.opcode == OP_LOAD_DP);
    next_dp_low = data_pointer_low;
    next_dp_high = data_pointer_high;
    if (load_dp) begin
      next_dp_high = issue_instr.op1;
      next_dp_low = issue_instr.op2;
    end else if (sfr_wr) begin
      if (sfr_addr == SFR_DP_LOW) next_dp_low = sfr_wdata;
      if (sfr_addr == SFR_DP_HIGH) next_dp_high = sfr_wdata;
    end
    // Unmapped addresses read back as zero
    case (sfr_addr)
      SFR_DP_LOW: next_sfr_rdata = data_pointer_low;
      SFR_DP_HIGH: next_sfr_rdata = data_pointer_high;
      default: next_sfr_rdata = SFR_UNMAPPED;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      data_pointer_low <= DP_RESET;
      data_pointer_high <= DP_RESET;
      sfr_rdata <= SFR_UNMAPPED;
    end else begin
      data_pointer_low <= next_dp_low;
      data_pointer_high <= next_dp_high;
      sfr_rdata <= next_sfr_rdata;
    end
  end

endmodule // cid_timing

//--- cid_timing_monitor.sv
// Port-level assertions for the instruction timing block
module cid_timing_monitor
  import cid_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Issue side
  input wire logic issue_valid,
  input cid_instr_t issue_instr,
  input cid_flags_t issue_flags,
  input wire logic issue_ready,
  // Results
  input wire logic done,
  input wire logic taken,
  input wire logic [PC_W-1:0] next_pc,
  input wire logic call_push,
  input wire logic return_pop,
  input wire logic [1:0] instr_len,
  input wire logic [CYC_W-1:0] cycles_used,
  input wire logic bit_clear,
  input wire logic dir_valid,
  input wire logic [7:0] dir_addr,
  input wire logic dir_is_sfr,
  // Function space and pointer pair
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] data_pointer_low,
  input wire logic [7:0] data_pointer_high
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  logic take;
  logic [7:0] op;
  assign take = issue_valid && issue_ready;
  assign op = issue_instr.opcode;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // Timing and target relations, measured from the accept edge or, for the pointer low write, from the port write
  a_logic_three: assert property (take && op == 8'h53 |=>
    instr_len == 2'h3 ##0 (!issue_ready [*2]) ##1 done)
    else $error("logic immediate timing off");
  a_acc_single: assert property (take && op == 8'he4 |=>
    done && cycles_used == 3'h1) else $error("accumulator op not single");
  a_unused_nop: assert property (take && op == OP_UNUSED |=>
    done && !taken && instr_len == 2'h1 && cycles_used == CYC_ONE)
    else $error("spare opcode differs from no operation");
  a_pointer_load: assert property (take && op == OP_LOAD_DP |=>
    data_pointer_high == $past(issue_instr.op1) &&
    data_pointer_low == $past(issue_instr.op2))
    else $error("pointer pair load wrong");
  a_long_call: assert property (take && op == 8'h12 |=>
    call_push && next_pc == {$past(issue_instr.op1), $past(issue_instr.op2)}
    ##0 (!done [*3]) ##1 done) else $error("long call wrong");
  a_return_five: assert property (take && (op == 8'h22 || op == 8'h32) |=>
    return_pop ##0 (!done [*4]) ##1 done)
    else $error("return timing wrong");
  a_carry_branch: assert property (take && op == 8'h40 |=>
    taken == $past(issue_flags.carry) && !done ##1 done == !taken)
    else $error("carry branch timing wrong");
  a_short_jump: assert property (take && op == 8'h80 |=>
    next_pc == $past(issue_instr.pc) + 16'h0002 +
    {{8{$past(issue_instr.op1[7])}}, $past(issue_instr.op1)})
    else $error("short jump target wrong");
  a_space_select: assert property (take && op == 8'h85 |=>
    dir_valid && dir_is_sfr == ($past(issue_instr.op1) > 8'h7f))
    else $error("space select wrong");
  a_low_write: assert property (sfr_wr && sfr_addr == SFR_DP_LOW &&
    !(take && op == OP_LOAD_DP) |=> data_pointer_low == $past(sfr_wdata))
    else $error("pointer low write lost");

  // Main scenarios reached
  c_taken: cover property (done && taken);
  c_clear: cover property (bit_clear);
  c_chain: cover property (take && done);
endmodule // cid_timing_monitor

bind cid_timing cid_timing_monitor mon_u (.clk_sys(clk_sys), .rst(rst),
  .issue_valid(issue_valid), .issue_instr(issue_instr),
  .issue_flags(issue_flags), .issue_ready(issue_ready), .done(done),
  .taken(taken), .next_pc(next_pc), .call_push(call_push),
  .return_pop(return_pop), .instr_len(instr_len),
  .cycles_used(cycles_used), .bit_clear(bit_clear), .dir_valid(dir_valid),
  .dir_addr(dir_addr), .dir_is_sfr(dir_is_sfr), .sfr_addr(sfr_addr),
  .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
  .data_pointer_low(data_pointer_low), .data_pointer_high(data_pointer_high));

//--- cid_code_model.sv
// Program memory model feeding instruction bytes to the block
module cid_code_model
  import cid_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Load port
  input wire logic wr,
  input wire logic [7:0] waddr,
  input wire logic [7:0] wdata,
  // Fetch port
  input wire logic [7:0] slot,
  input wire logic [PC_W-1:0] pc,
  output cid_instr_t instr
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [256];
  // Unloaded bytes stay unknown, so a stray fetch shows up
  always_ff @(posedge clk_sys) if (wr) mem[waddr] <= wdata;
  assign instr = '{mem[slot], mem[slot + 8'h01], mem[slot + 8'h02], pc};
endmodule // cid_code_model

//--- cid_timing_bench.sv
// Self-checking bench for the instruction timing block
module cid_timing_bench
  import cid_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, rst, issue_valid, issue_ready, done, taken, call_push;
  logic return_pop, known, bit_clear, dir_valid, dir_is_sfr, sfr_wr, wr;
  logic [7:0] dir_addr, sfr_addr, sfr_wdata, sfr_rdata, waddr, wdata, slot;
  logic [7:0] data_pointer_low, data_pointer_high;
  logic [PC_W-1:0] next_pc, ipc, dp;
  logic [1:0] instr_len;
  logic [CYC_W-1:0] cycles_used;
  cid_instr_t issue_instr;
  cid_flags_t issue_flags;
  logic [31:0] r;
  int err_count = 0, num_checks = 0;
  // ----------------------------------------------------------------
  // Opcode, length, base cycles, kind (1/2 cond, 3 rel, 4 page, 5 full,
  // 6 indirect, 7 return, 8 unknown, 9/a calls)
  // ----------------------------------------------------------------
  localparam logic [19:0] TAB [51] = '{
    20'h53330, 20'he4110, 20'hf4110, 20'h23110, 20'h33110, 20'h03110,
    20'h13110, 20'hc4110, 20'he8110, 20'he6120, 20'h85330, 20'h75330,
    20'h90330, 20'h93130, 20'h83130, 20'he2130, 20'hf2130, 20'he0130,
    20'hf0130, 20'hc0220, 20'hd0220, 20'hd6120, 20'hc3110, 20'h82220,
    20'hb0220, 20'h40221, 20'h50222, 20'h60221, 20'h70222, 20'h20331,
    20'h30332, 20'h10331, 20'hb5341, 20'hb4331, 20'hb8331, 20'hb6341,
    20'hd8221, 20'hd5331, 20'h11239, 20'hf1239, 20'h1234a, 20'h22157,
    20'h32157, 20'h01234, 20'he1234, 20'h02345, 20'h80233, 20'h73136,
    20'h00110, 20'ha5110, 20'h24118};

  cid_timing dut_u (.clk_sys(clk_sys), .rst(rst),
    .issue_valid(issue_valid), .issue_instr(issue_instr),
    .issue_flags(issue_flags), .issue_ready(issue_ready), .done(done),
    .taken(taken), .next_pc(next_pc), .call_push(call_push),
    .return_pop(return_pop), .known(known), .instr_len(instr_len),
    .cycles_used(cycles_used), .bit_clear(bit_clear),
    .dir_valid(dir_valid), .dir_addr(dir_addr), .dir_is_sfr(dir_is_sfr),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .data_pointer_low(data_pointer_low),
    .data_pointer_high(data_pointer_high));
  cid_code_model mem_u (.clk_sys(clk_sys), .wr(wr), .waddr(waddr),
    .wdata(wdata), .slot(slot), .pc(ipc), .instr(issue_instr));

  function automatic logic [31:0] lfsr(logic [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Target from kind; the page form keeps the page of the next byte
  function automatic logic [15:0] exp_pc(logic [19:0] e, cid_instr_t n,
      logic tk, logic [7:0] acc);
    logic [15:0] nx;
    logic [7:0] rl;
    nx = n.pc + 16'(e[11:8]);
    rl = (e[11:8] == 4'h3) ? n.op2 : n.op1;
    case (e[3:0])
      4'h1, 4'h2: exp_pc = tk ? nx + {{8{rl[7]}}, rl} : nx;
      4'h3: exp_pc = nx + {{8{rl[7]}}, rl};
      4'h4, 4'h9: exp_pc = {nx[15:11], n.opcode[7:5], n.op1};
      4'h5, 4'ha: exp_pc = {n.op1, n.op2};
      4'h6: exp_pc = dp + {8'h00, acc};
      default: exp_pc = nx;
    endcase
  endfunction

  task automatic chk(logic [15:0] got, logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask
  task automatic close_out();
    if (err_count == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Pointer byte write then read back; unmapped place reads zero
  task automatic special_function_space(logic [7:0] a);
    r = lfsr(r);
    sfr_addr = a;
    sfr_wr = 1'b1;
    sfr_wdata = r[7:0];
    if (a == SFR_DP_LOW) dp[7:0] = r[7:0];
    if (a == SFR_DP_HIGH) dp[15:8] = r[7:0];
    @(negedge clk_sys);
    sfr_wr = 1'b0;
    @(negedge clk_sys);
    chk(sfr_rdata, (a[7:1] == 7'h41) ? r[7:0] : 8'h00);
    chk({data_pointer_high, data_pointer_low}, dp);
  endtask
  // One issue; valid stays up after a one-cycle op to chain the next
  task automatic run(int i, logic tk);
    logic [19:0] e;
    logic [3:0] kd, cy;
    logic f, tx;
    int k;
    e = TAB[i];
    kd = e[3:0];
    r = lfsr(r);
    f = (kd == 4'h2) ? !tk : tk;
    tx = (kd inside {4'h1, 4'h2}) ? tk : (kd > 4'h2 && kd != 4'h8);
    cy = e[7:4] + 4'((kd inside {4'h1, 4'h2}) && tk);
    slot = 8'(i * 3);
    ipc = tk ? {r[15:11], 11'h7fe} : r[15:0];
    issue_flags = '{f, f, f, f, f, r[23:16]};
    issue_valid = 1'b1;
    @(posedge clk_sys);
    k = 0;
    do begin
      @(negedge clk_sys);
      k++;
      if (k == 1) begin
        chk(taken, tx);
        chk(next_pc, exp_pc(e, issue_instr, tk, r[23:16]));
        chk(instr_len, e[11:8]);
        chk(cycles_used, cy);
        chk(known, kd != 4'h8);
        chk(call_push, kd > 4'h8);
        chk(return_pop, kd == 4'h7);
        if (e[19:12] == OP_LOAD_DP) dp = {issue_instr.op1, issue_instr.op2};
        if (!done) issue_valid = 1'b0;
      end
    end while (!done && k < 8);
    chk(16'(k), cy);
    chk(bit_clear, e[19:12] == 8'h10 && tk);
  endtask

  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // Watchdog, several times the run's length
  initial begin
    #400000;
    err_count++;
    close_out();
  end
  // Main sequence
  initial begin
    {rst, wr, sfr_wr, issue_valid} = 4'h8;
    {sfr_addr, sfr_wdata, waddr, wdata, slot} = '0;
    {ipc, dp, issue_flags} = '0;
    r = 32'h7ac24670;
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    @(negedge clk_sys);
    chk({data_pointer_high, data_pointer_low}, 16'h0000);
    chk(issue_ready, 1'b1);
    for (int i = 0; i < 153; i++) begin
      r = lfsr(r);
      wr = 1'b1;
      waddr = 8'(i);
      wdata = (i % 3 == 0) ? TAB[i / 3][19:12] : r[7:0];
      @(negedge clk_sys);
    end
    wr = 1'b0;
    special_function_space(SFR_DP_LOW);
    special_function_space(SFR_DP_HIGH);
    special_function_space(8'h84);
    for (int i = 0; i < 51; i++) begin
      for (int t = 0; t < 2; t++) run(i, t[0]);
    end
    issue_valid = 1'b0;
    close_out();
  end
endmodule // cid_timing_bench
